// file: src/pcint_regs.svh
// register map, field positions and reset values of the pin change block
// assumes a 32-bit wishbone slave, one register per aligned word
`ifndef PCINT_REGS_SVH
`define PCINT_REGS_SVH

// per-port block: port p starts at p * stride
`define PCINT_PORT_STRIDE 8'h10
`define PCINT_OFF_RISE    8'h00
`define PCINT_OFF_FALL    8'h04
`define PCINT_OFF_FLAG    8'h08

// block-wide registers
`define PCINT_OFF_CTRL    8'h50
`define PCINT_OFF_STAT    8'h54
`define PCINT_OFF_MASK    8'h58

// control register fields
`define PCINT_CTRL_MEN    0
`define PCINT_CTRL_SUM    1

// status and mask fields
`define PCINT_STAT_CHG    0
`define PCINT_STAT_WAKE   1

// reset values
`define PCINT_RST_BYTE    8'h00
`define PCINT_RST_STAT    2'h0

// implemented pins of port e
`define PCINT_PORTE_MASK  8'h08

// cycles after reset before edges are trusted
`define PCINT_SETTLE      3'h5

`endif

// file: src/pcint_pkg.sv
// types shared by the pin change block
// assumes the constants header is included where offsets are needed
package pcint_pkg;
  typedef logic [7:0] pcint_byte_t;
  typedef logic [1:0] pcint_stat_t;
endpackage

// file: src/pcint_port.sv
// one port of pin change detection: synchroniser, filter, edge detectors
// assumes pins are asynchronous to clk_i and enables come from clk_i logic
`timescale 1ns/1ns
`default_nettype none
`include "pcint_regs.svh"
module pcint_port #(
  parameter int             W    = 8,
  parameter logic [W-1:0]   IMPL = '1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // pins and enables
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] rise_en_i,
  input  wire logic [W-1:0] fall_en_i,
  // detected enabled edges, one cycle each
  output logic      [W-1:0] edge_o
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  logic [W-1:0] filt_q, prev_q;
  logic [2:0]   cnt_q;
  logic         armed;

  // the masks and detectors need at least one pin
  if (W < 1) begin : g_bad_w
    $error("pcint_port: W must be at least 1");
  end

  // three stage synchroniser; s1_q feeds only s2_q
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level moves only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_q <= '0;
      prev_q <= '0;
    end else begin
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
      prev_q <= filt_q;
    end
  end

  // hold off edges until the pipe holds real pin levels,
  // otherwise a pin high at reset would look like a rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
    end else if (cnt_q != `PCINT_SETTLE) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  assign armed = (cnt_q == `PCINT_SETTLE);

  // compare sample with previous one, each direction gated [RULE_18]
  always_comb begin
    edge_o = '0;
    if (armed) begin
      edge_o = IMPL & ((filt_q & ~prev_q & rise_en_i)    // [RULE_03]
                     | (~filt_q & prev_q & fall_en_i));  // [RULE_04] [RULE_05]
    end
  end

  // a direction may only fire through its own enable bit
  a_rise_gated: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE_03]
    ((edge_o & filt_q & ~rise_en_i) == '0))
    else $error("rising edge without its enable");

  a_fall_gated: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE_04]
    ((edge_o & ~filt_q & ~fall_en_i) == '0))
    else $error("falling edge without its enable");
endmodule
`default_nettype wire

// file: src/pcint_top.sv
// pin change interrupt block with wishbone register access
// assumes a classic wishbone master on clk_i and asynchronous port pins
// Function
// RULE_01 - every pin of every port may be enabled for change detection, any mix; port e here has only pin 3 implemented
// RULE_02 - master enable clear: flags still set, no interrupt request raised
// RULE_03 - rising edge seen only while its rise enable bit is set
// RULE_04 - falling edge seen only while its fall enable bit is set
// RULE_05 - both enables set: edges of either direction are seen
// RULE_06 - enabled edge sets pin flag; request raised if master enable set
// RULE_07 - read-only summary flag is the OR of all pin flags
// RULE_08 - writing zero to a flag bit clears it
// RULE_09 - edge during a flag write leaves the flag set afterwards
// RULE_10 - software clears flags by AND masking only the bits it saw
// RULE_11 - with master enable set, an enabled edge wakes the core from sleep
// RULE_12 - flags are updated before the core runs after wake
// RULE_13 - port a rise enable: 8 bits read/write, zero after reset
// RULE_14 - port a fall enable: 8 bits read/write, zero after reset
// RULE_15 - port a flags: 8 bits, hardware set, read/write, zero after reset
// RULE_16 - port e implements pin 3 only; other enable bits read zero
// RULE_17 - a zero flag means no enabled change since the last clear
// RULE_18 - edges found by sample versus previous sample; set beats clear
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pcint_regs.svh"
module pcint_top #(
  parameter int PORT_W = 8,
  parameter int ADR_W  = 8
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // port pins
  input  wire pcint_pkg::pcint_byte_t port_a_i,
  input  wire pcint_pkg::pcint_byte_t port_b_i,
  input  wire pcint_pkg::pcint_byte_t port_c_i,
  input  wire pcint_pkg::pcint_byte_t port_d_i,
  input  wire pcint_pkg::pcint_byte_t port_e_i,
  // core side
  input  wire logic                sleep_i,
  output logic                     pin_change_irq_o,
  output logic                     wake_o,
  output logic                     irq_o
);
  import pcint_pkg::*;

  localparam int NP = 5;

  // the register layout is byte wide per port
  if (PORT_W != 8) begin : g_bad_width
    $error("pcint_top: PORT_W must be 8");
  end
  if (ADR_W < 8) begin : g_bad_adr
    $error("pcint_top: ADR_W must be at least 8");
  end

  // implemented pins of port p
  function automatic pcint_byte_t impl_mask(input int p);
    return (p == NP - 1) ? `PCINT_PORTE_MASK : 8'hff;
  endfunction

  // byte offset of register k of port p
  function automatic logic [7:0] port_off(input int p, input logic [7:0] k);
    return 8'(p) * `PCINT_PORT_STRIDE + k;
  endfunction

  // full address match against a byte offset
  function automatic logic is_reg(input logic [ADR_W-1:0] a, input logic [7:0] off);
    return a == ADR_W'(off);
  endfunction

  pcint_byte_t pins    [NP];
  pcint_byte_t edge_w  [NP];
  pcint_byte_t rise_q  [NP];
  pcint_byte_t fall_q  [NP];
  pcint_byte_t flags_q [NP];
  pcint_byte_t flags_d [NP];

  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic        req;
  logic        wr_go;
  logic        master_q, master_d;
  logic        summary_q;
  logic        pcirq_q;
  logic        wake_q;
  logic        irq_q;
  logic        edge_any;
  logic        flag_any_d;
  pcint_stat_t stat_q, stat_d;
  pcint_stat_t mask_q, mask_d;
  pcint_stat_t stat_set;
  logic [8*NP-1:0] edge_all, flags_all, rise_all, fall_all;

  assign pins[0] = port_a_i;
  assign pins[1] = port_b_i;
  assign pins[2] = port_c_i;
  assign pins[3] = port_d_i;
  assign pins[4] = port_e_i;

  // one detector per port; port e carries only pin 3 [RULE_01] [RULE_16]
  for (genvar g = 0; g < NP; g++) begin : g_port
    pcint_port #(
      .W    (PORT_W),
      .IMPL (impl_mask(g))
    ) u_port (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pin_i     (pins[g]),
      .rise_en_i (rise_q[g]),
      .fall_en_i (fall_q[g]),
      .edge_o    (edge_w[g])
    );
  end

  // flat views for or-reduction and checks
  always_comb begin
    edge_all  = '0;
    flags_all = '0;
    rise_all  = '0;
    fall_all  = '0;
    for (int p = 0; p < NP; p++) begin
      edge_all[8*p +: 8]  = edge_w[p];
      flags_all[8*p +: 8] = flags_q[p];
      rise_all[8*p +: 8]  = rise_q[p];
      fall_all[8*p +: 8]  = fall_q[p];
    end
  end
  assign edge_any = |edge_all;

  // bus handshake: ack one cycle after the request, dropped the next
  assign req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wr_go = req & wb_we_i & ack_q & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read mux; unmapped words read as zero and are still acked
  always_comb begin
    rd_d = 32'h0;
    for (int p = 0; p < NP; p++) begin
      if (is_reg(wb_adr_i, port_off(p, `PCINT_OFF_RISE))) begin
        rd_d = {24'h0, rise_q[p]};
      end
      if (is_reg(wb_adr_i, port_off(p, `PCINT_OFF_FALL))) begin
        rd_d = {24'h0, fall_q[p]};
      end
      if (is_reg(wb_adr_i, port_off(p, `PCINT_OFF_FLAG))) begin
        rd_d = {24'h0, flags_q[p]};
      end
    end
    if (is_reg(wb_adr_i, `PCINT_OFF_CTRL)) begin
      rd_d = {30'h0, summary_q, master_q};  // [RULE_07]
    end
    if (is_reg(wb_adr_i, `PCINT_OFF_STAT)) begin
      rd_d = {30'h0, stat_q};
    end
    if (is_reg(wb_adr_i, `PCINT_OFF_MASK)) begin
      rd_d = {30'h0, mask_q};
    end
  end

  // read data captured with the rising ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (req & ~ack_q) begin
      dat_q <= rd_d;
    end
  end

  // edge enables; unimplemented bits never store [RULE_13] [RULE_14] [RULE_16]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < NP; p++) begin
        rise_q[p] <= `PCINT_RST_BYTE;
        fall_q[p] <= `PCINT_RST_BYTE;
      end
    end else if (wr_go) begin
      for (int p = 0; p < NP; p++) begin
        if (is_reg(wb_adr_i, port_off(p, `PCINT_OFF_RISE))) begin
          rise_q[p] <= wb_dat_i[7:0] & impl_mask(p);
        end
        if (is_reg(wb_adr_i, port_off(p, `PCINT_OFF_FALL))) begin
          fall_q[p] <= wb_dat_i[7:0] & impl_mask(p);
        end
      end
    end
  end

  // flags: write stores, a fresh edge is or-ed in last so it wins
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      flags_d[p] = flags_q[p];
      if (wr_go && is_reg(wb_adr_i, port_off(p, `PCINT_OFF_FLAG))) begin
        flags_d[p] = wb_dat_i[7:0] & impl_mask(p);  // [RULE_08] [RULE_17]
      end
      flags_d[p] = flags_d[p] | edge_w[p];           // [RULE_06] [RULE_09] [RULE_18]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < NP; p++) begin
        flags_q[p] <= `PCINT_RST_BYTE;                // [RULE_15]
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        flags_q[p] <= flags_d[p];
      end
    end
  end

  // or of next flags keeps the summary in step with the flags
  always_comb begin
    flag_any_d = 1'b0;
    for (int p = 0; p < NP; p++) begin
      flag_any_d = flag_any_d | (|flags_d[p]);
    end
  end

  // master enable in the control register
  always_comb begin
    master_d = master_q;
    if (wr_go && is_reg(wb_adr_i, `PCINT_OFF_CTRL)) begin
      master_d = wb_dat_i[`PCINT_CTRL_MEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_q  <= 1'b0;
      summary_q <= 1'b0;
      pcirq_q   <= 1'b0;
    end else begin
      master_q  <= master_d;
      summary_q <= flag_any_d;                       // [RULE_07]
      pcirq_q   <= master_d & flag_any_d;            // [RULE_02] [RULE_06]
    end
  end

  // wake pulse shares the edge that sets the flag, so flags lead the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleep_i & master_q & edge_any;       // [RULE_11] [RULE_12]
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_comb begin
    stat_set = '0;
    stat_set[`PCINT_STAT_CHG]  = master_q & edge_any;  // [RULE_02]
    stat_set[`PCINT_STAT_WAKE] = sleep_i & master_q & edge_any;
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_go && is_reg(wb_adr_i, `PCINT_OFF_STAT)) begin
      stat_d = stat_q & ~wb_dat_i[1:0];
    end
    if (wr_go && is_reg(wb_adr_i, `PCINT_OFF_MASK)) begin
      mask_d = wb_dat_i[1:0];
    end
    stat_d = stat_d | stat_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= `PCINT_RST_STAT;
      mask_q <= `PCINT_RST_STAT;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= |(stat_d & mask_d);
    end
  end

  // outputs straight from flops
  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = dat_q;
  assign pin_change_irq_o = pcirq_q;
  assign wake_o           = wake_q;
  assign irq_o            = irq_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_edge_sets_flag: assert property ((edge_all != '0) |=>   // [RULE_06]
    ((flags_all & $past(edge_all)) == $past(edge_all)))
    else $error("edge did not set its flag");

  a_edge_in_write: assert property ((wr_go && (edge_all != '0)) |=>  // [RULE_09]
    ((flags_all & $past(edge_all)) == $past(edge_all)))
    else $error("flag lost to a write");

  a_clear_porta: assert property ((wr_go && is_reg(wb_adr_i, `PCINT_OFF_FLAG)  // [RULE_08]
    && edge_w[0] == 8'h00) |=> (flags_q[0] == $past(wb_dat_i[7:0])))
    else $error("port a flag write wrong");

  a_edge_needs_en: assert property ((edge_all & ~(rise_all | fall_all)) == '0)  // [RULE_05]
    else $error("edge on a disabled pin");

  a_no_irq_off: assert property (!master_q |-> !pin_change_irq_o)  // [RULE_02]
    else $error("request raised with master off");

  a_irq_follows: assert property ((master_q && edge_any) |=> (pin_change_irq_o || !master_q))  // [RULE_06]
    else $error("request missing after edge");

  a_summary_or: assert property (summary_q == (flags_all != '0))  // [RULE_07]
    else $error("summary flag differs from flags");

  a_porte_bits: assert property (((rise_q[4] | fall_q[4] | flags_q[4])  // [RULE_16]
    & ~`PCINT_PORTE_MASK) == 8'h00)
    else $error("unimplemented port e bit set");

  a_wake_pulse: assert property ((sleep_i && master_q && edge_any) |=>  // [RULE_11]
    (wake_o && summary_q))
    else $error("wake missing or flags late");

  a_wake_cause: assert property (wake_o |-> ($past(sleep_i) && $past(master_q)))  // [RULE_12]
    else $error("wake without cause");

  a_reset_clear: assert property (disable iff (1'b0) $past(rst_i) |->  // [RULE_15]
    (rise_all == '0 && fall_all == '0 && flags_all == '0))
    else $error("register not zero after reset");

  a_flag_held: assert property ((!wr_go && flags_q[0][0]) |=> flags_q[0][0])  // [RULE_17]
    else $error("flag dropped without a clear");

  a_ack_once: assert property ((req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  c_both_edges: cover property (edge_w[0][0] ##[1:200] edge_w[0][0]);
  c_wake: cover property (wake_o);
  c_set_and_clear: cover property (wr_go && edge_any);
  c_irq: cover property (irq_o && pin_change_irq_o);
endmodule
`default_nettype wire

// file: dv/pcint_pins.sv
// board model: drives the five groups of port pins of the block
// assumes the bench calls set_port just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module pcint_pins (
  // pin levels, port a in bits 7:0 up to port e in bits 39:32
  output logic [39:0] pins_o
);
  // board straps every pin low until it is driven
  initial pins_o = 40'h0;

  // a level holds until the next call, so edges stay several cycles apart
  task automatic set_port(input int p, input logic [7:0] v);
    pins_o[p*8 +: 8] <= v;
  endtask
endmodule
`default_nettype wire

// file: dv/pin_change_interrupt_bench.sv
// self-checking bench for the pin change block, random and corner stimulus
// assumes the design answers every bus cycle and settles pins in ~5 cycles
`timescale 1ns/1ns
`default_nettype none
module pin_change_interrupt_bench;
  import pcint_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, sleep, chg, wake, irq, seen;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, rv;
  wire  logic [39:0] pins;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          seed = 32'h199de254;
  pcint_byte_t r, f, o, n, e, acc;

  pcint_pins i_pins (.pins_o(pins));
  pcint_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .port_a_i(pins[7:0]), .port_b_i(pins[15:8]), .port_c_i(pins[23:16]),
    .port_d_i(pins[31:24]), .port_e_i(pins[39:32]), .sleep_i(sleep),
    .pin_change_irq_o(chg), .wake_o(wake), .irq_o(irq));

  // free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, x, g);
    end
  endtask

  // one classic cycle; entered just after a rising edge, holds until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= s;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = dat_r;
    if (k >= 50) check("ack", 1, 0);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask

  // enabled edges between two pin samples
  function automatic pcint_byte_t edges(pcint_byte_t a, pcint_byte_t b, pcint_byte_t er,
                                        pcint_byte_t ef);
    return (er & ~a & b) | (ef & a & ~b);
  endfunction

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog: the whole run takes well under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    dat_w = 32'h0; sleep = 1'b0; acc = 8'h00;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // every register and the unmapped words read zero after reset
    for (int a = 0; a < 'h60; a += 4) begin
      wb(0, a, 0, 4'hf, rv);
      check("reset value", 0, rv);
    end
    // enables read back; port e keeps pin 3 only; sel[0] low is ignored
    for (int p = 0; p < 5; p++) begin
      for (int m = 0; m < 8; m += 4) begin
        r = $random(seed);
        wb(1, p*16+m, r, 4'hf, rv);
        wb(1, p*16+m, ~r, 4'he, rv);
        wb(0, p*16+m, 0, 4'hf, rv);
        check("enable", (p == 4) ? r & 8'h08 : r, rv);
      end
    end
    // edges with master enable off: flags set, no request
    for (int k = 0; k < 6; k++) begin
      int p;
      p = k % 5;
      r = (k == 5) ? 8'hff : $random(seed);
      f = (k == 5) ? 8'hff : $random(seed);
      o = pins[p*8 +: 8];
      n = (k == 5) ? ~o : $random(seed);
      wb(1, p*16, r, 4'hf, rv);
      wb(1, p*16+4, f, 4'hf, rv);
      wb(1, p*16+8, 0, 4'hf, rv);
      i_pins.set_port(p, n);
      repeat (8) @(posedge clk_i);
      e = edges(o, n, r, f) & ((p == 4) ? 8'h08 : 8'hff);
      acc = (k == 5) ? e : acc | e;
      wb(0, p*16+8, 0, 4'hf, rv);
      check("flags", e, rv);
      check("request", 0, chg);
      wb(0, 8'h50, 0, 4'hf, rv);
      check("summary", {30'h0, |acc, 1'b0}, rv);
    end
    // software clear by masking the bits it saw
    for (int p = 0; p < 5; p++) begin
      wb(0, p*16+8, 0, 4'hf, rv);
      o = rv[7:0];
      wb(0, p*16+8, 0, 4'hf, rv);
      wb(1, p*16+8, rv & ~{24'h0, o}, 4'hf, rv);
      wb(0, p*16+8, 0, 4'hf, rv);
      check("cleared", 0, rv);
    end
    // wake from sleep on a rising edge with master enable set
    wb(1, 8'h04, 0, 4'hf, rv);
    wb(1, 8'h00, 1, 4'hf, rv);
    i_pins.set_port(0, pins[7:0] & 8'hfe);
    repeat (8) @(posedge clk_i);
    wb(1, 8'h50, 1, 4'hf, rv);
    wb(1, 8'h58, 3, 4'hf, rv);
    sleep <= 1'b1;
    seen = 1'b0;
    i_pins.set_port(0, pins[7:0] | 8'h01);
    repeat (12) begin
      @(posedge clk_i);
      if (wake === 1'b1) seen = 1'b1;
    end
    sleep <= 1'b0;
    check("wake", 1, seen);
    check("request", 1, chg);
    check("irq", 1, irq);
    wb(0, 8'h08, 0, 4'hf, rv);
    check("flag after wake", 1, rv);
    wb(0, 8'h54, 0, 4'hf, rv);
    check("status", 3, rv);
    wb(1, 8'h54, 3, 4'hf, rv);
    @(posedge clk_i);
    check("irq cleared", 0, irq);
    // edge landing with or just after a clearing write survives it
    wb(1, 8'h04, 1, 4'hf, rv);
    for (int d = 0; d < 4; d++) begin
      wb(1, 8'h08, 0, 4'hf, rv);
      i_pins.set_port(0, pins[7:0] ^ 8'h01);
      repeat (d) @(posedge clk_i);
      wb(1, 8'h08, 0, 4'hf, rv);
      repeat (8) @(posedge clk_i);
      wb(0, 8'h08, 0, 4'hf, rv);
      check("flag kept", 1, rv[0]);
    end
    // reset in mid-run clears enables and flags again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 'h0c; a += 4) begin
      wb(0, a, 0, 4'hf, rv);
      check("after reset", 0, rv);
    end
    final_report();
  end
endmodule
`default_nettype wire
